// file: shared/smb_pkg.sv
package smb_pkg;

  // ==========================================================================
  // Field widths
  localparam int ID_W    = 16;
  localparam int TAG_W   = 16;
  localparam int LUN_W   = 64;
  localparam int ADDR_W  = 32;
  localparam int CNT_W   = 32;
  localparam int ROUTE_W = 32;

  // ==========================================================================
  // Message constants
  localparam logic [7:0] CTRL_SEND       = 8'h00;
  localparam logic [7:0] MSG_CODE_TM     = 8'h83;
  localparam logic [7:0] MSG_TAG_ZERO    = 8'h00;
  localparam logic [7:0] SUB_ABORT_TASK  = 8'h30;
  localparam logic [7:0] SUB_ABORT_SET   = 8'h31;
  localparam logic [7:0] SUB_CLEAR_SET   = 8'h32;
  localparam logic [7:0] SUB_TARGET_RST  = 8'h33;
  localparam logic [7:0] SUB_CLEAR_ACA   = 8'h34;
  localparam logic [7:0] SUB_LUN_RST     = 8'h35;
  // Byte size of the built structure per message shape
  localparam logic [7:0] LEN_ROUTE_ONLY  = 8'h08;
  localparam logic [7:0] LEN_ROUTE_SECOND_TASK_TAG  = 8'h0A;
  localparam logic [7:0] LEN_ROUTE_LUN   = 8'h10;
  localparam logic [7:0] LEN_LUN_ONLY    = 8'h0C;

  // ==========================================================================
  // Codes and states
  typedef enum logic [2:0] {
    FN_ABORT_TASK = 3'h0, FN_ABORT_SET = 3'h1, FN_CLEAR_ACA = 3'h2, FN_CLEAR_SET = 3'h3,
    FN_TARGET_RST = 3'h4, FN_LUN_RST = 3'h5, FN_TERMINATE = 3'h6
  } smb_tm_fn_t;

  typedef enum logic [1:0] {
    RC_SUCCESS = 2'h0, RC_FAILED = 2'h1, RC_INVALID_PARAM = 2'h2, RC_INVALID_FIELD = 2'h3
  } smb_rc_t;

  typedef enum logic [1:0] {
    SR_FUNC_COMPLETE = 2'h0, SR_FUNC_REJECTED = 2'h1, SR_DELIVERY_FAIL = 2'h2
  } smb_sr_t;

  typedef enum logic [1:0] {ST_IDLE, ST_LOOKUP, ST_SEND, ST_WAIT_RSP} smb_tm_st_t;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [ID_W-1:0]  dest;
    logic [TAG_W-1:0] tag;
    logic [LUN_W-1:0] lun;
  } smb_xfer_done_t;

  typedef struct packed {
    logic [ID_W-1:0]  dest;
    logic [ID_W-1:0]  src;
    logic [TAG_W-1:0] tag;
    logic [LUN_W-1:0] lun;
  } smb_confirm_t;

  typedef struct packed {
    logic [ID_W-1:0]   dest;
    logic [ID_W-1:0]   src;
    logic [TAG_W-1:0]  tag;
    logic [LUN_W-1:0]  lun;
    logic [ADDR_W-1:0] offset;
    logic [CNT_W-1:0]  count;
    logic [ADDR_W-1:0] buf_addr;
  } smb_dout_req_t;

  typedef struct packed {
    logic [ID_W-1:0]   dest;
    logic [TAG_W-1:0]  tag;
    logic [ADDR_W-1:0] buf_addr;
    logic [ADDR_W-1:0] offset;
    logic [CNT_W-1:0]  count;
  } smb_twrite_t;

  typedef struct packed {
    logic [ID_W-1:0]  dest;
    logic [TAG_W-1:0] tag;
    logic [LUN_W-1:0] lun;
    smb_sr_t          resp;
  } smb_cmd_cpl_t;

  typedef struct packed {
    smb_tm_fn_t       fn;
    logic [ID_W-1:0]  dest;
    logic [LUN_W-1:0] lun;
    logic [TAG_W-1:0] tag;
  } smb_tm_req_t;

  typedef struct packed {
    logic [7:0]         message_code;
    logic [7:0]         protocol_subcode;
    logic [7:0]         tag;
    logic [ROUTE_W-1:0] return_route_id;
    logic [LUN_W-1:0]   lun;
    logic [TAG_W-1:0]   second_task_tag;
  } smb_short_message_t;

  typedef struct packed {
    logic [7:0]         control;
    logic [ID_W-1:0]    dest;
    logic [7:0]         length;
    smb_short_message_t msg;
  } smb_send_t;

endpackage : smb_pkg

// file: rtl/smb_msg_builder.sv
`timescale 1ns/1ps

// Functional notes
// RULE_01: Read completion raises data-sent confirmation with own id as source.
// RULE_02: Data-out request invokes target write with buffer, offset and count mapped.
// RULE_03: Target write failure issues command-complete with delivery or target failure.
// RULE_04: Each target write leads to a matching initiator write at the far end.
// RULE_05: Write completion raises data-out-received confirmation with own id as source.
// RULE_06: Task messages sent with control zero, request destination, structure length.
// RULE_07: Send failed or invalid field gives failure; success gives function complete.
// RULE_08: Only one task management request outstanding; others are held.
// RULE_09: Abort task: 83h/30h, zero tag, looked-up route, second tag holds task tag.
// RULE_10: Abort task set: 83h/31h, zero tag, looked-up route, unit from request.
// RULE_11: Clear contingent allegiance: 83h/34h, zero tag, unit field, no route.
// RULE_12: Clear task set: 83h/32h, zero tag, looked-up route, unit from request.
// RULE_13: Target reset: 83h/33h, zero tag, looked-up route, no unit field.
// RULE_14: Unit reset: 83h/35h, zero tag, unit from request, looked-up route.
// RULE_15: Terminate task always answered function rejected, no message sent.
// RULE_16: Response message code maps to rejected, complete or failure.
// RULE_17: Held requests released in arrival order after previous response delivered.
module smb_msg_builder (
  input  wire logic                               core_clk,
  input  wire logic                               rst,
  input  wire logic [smb_pkg::ID_W-1:0]           own_id,
  input  wire logic                               rd_done_valid,
  input  wire smb_pkg::smb_xfer_done_t            rd_done,
  input  wire logic                               wr_done_valid,
  input  wire smb_pkg::smb_xfer_done_t            wr_done,
  input  wire logic                               dout_valid,
  input  wire smb_pkg::smb_dout_req_t             dout_req,
  input  wire logic                               tw_ret_valid,
  input  wire smb_pkg::smb_rc_t                   tw_ret,
  input  wire logic                               tm_valid,
  input  wire smb_pkg::smb_tm_req_t               tm_req,
  input  wire logic                               route_ack,
  input  wire logic [smb_pkg::ROUTE_W-1:0]        route_id,
  input  wire logic                               send_ret_valid,
  input  wire smb_pkg::smb_rc_t                   send_ret,
  input  wire logic                               tm_msg_valid,
  input  wire smb_pkg::smb_rc_t                   tm_msg_rc,
  output logic                                    data_sent_valid,
  output smb_pkg::smb_confirm_t                   data_sent,
  output logic                                    dout_rcvd_valid,
  output smb_pkg::smb_confirm_t                   dout_rcvd,
  output logic                                    tw_valid,
  output smb_pkg::smb_twrite_t                    tw,
  output logic                                    cmd_cpl_valid,
  output smb_pkg::smb_cmd_cpl_t                   cmd_cpl,
  output logic                                    tm_ready,
  output logic                                    route_req,
  output logic [smb_pkg::ID_W-1:0]                route_dest,
  output logic                                    send_valid,
  output smb_pkg::smb_send_t                      send,
  output logic                                    tm_rsp_valid,
  output smb_pkg::smb_sr_t                        tm_rsp,
  output logic                                    tm_exec_valid,
  output smb_pkg::smb_sr_t                        tm_exec_rsp
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic                          ds_valid;
    smb_pkg::smb_confirm_t         ds;
    logic                          dr_valid;
    smb_pkg::smb_confirm_t         dr;
    logic                          tw_valid;
    smb_pkg::smb_twrite_t          tw;
    logic [smb_pkg::LUN_W-1:0]     tw_lun;
    logic                          cc_valid;
    smb_pkg::smb_cmd_cpl_t         cc;
    smb_pkg::smb_tm_st_t           st;
    logic                          ready;
    smb_pkg::smb_tm_req_t          req;
    logic                          route_req;
    logic                          send_valid;
    smb_pkg::smb_send_t            send;
    logic                          rsp_valid;
    smb_pkg::smb_sr_t              rsp;
    logic                          exec_valid;
    smb_pkg::smb_sr_t              exec_rsp;
  } smb_state_t;

  smb_state_t state_r;
  smb_state_t state_nxt;

  // ==========================================================================
  // Message builder
  function automatic smb_pkg::smb_send_t build_msg(input smb_pkg::smb_tm_req_t r,
                                                   input logic [smb_pkg::ROUTE_W-1:0] rid);
    smb_pkg::smb_send_t m;
    m                      = '0;
    m.control              = smb_pkg::CTRL_SEND;                              // [RULE_06]
    m.dest                 = r.dest;                                          // [RULE_06]
    m.msg.message_code     = smb_pkg::MSG_CODE_TM;
    m.msg.tag              = smb_pkg::MSG_TAG_ZERO;
    case (r.fn)
      smb_pkg::FN_ABORT_TASK: begin
        m.msg.protocol_subcode = smb_pkg::SUB_ABORT_TASK;                     // [RULE_09]
        m.msg.return_route_id  = rid;                                         // [RULE_09]
        m.msg.second_task_tag  = r.tag;                                       // [RULE_09]
        m.length               = smb_pkg::LEN_ROUTE_SECOND_TASK_TAG;
      end
      smb_pkg::FN_ABORT_SET: begin
        m.msg.protocol_subcode = smb_pkg::SUB_ABORT_SET;                      // [RULE_10]
        m.msg.return_route_id  = rid;                                         // [RULE_10]
        m.msg.lun              = r.lun;                                       // [RULE_10]
        m.length               = smb_pkg::LEN_ROUTE_LUN;
      end
      smb_pkg::FN_CLEAR_ACA: begin
        m.msg.protocol_subcode = smb_pkg::SUB_CLEAR_ACA;                      // [RULE_11]
        m.msg.lun              = r.lun;                                       // [RULE_11]
        m.length               = smb_pkg::LEN_LUN_ONLY;
      end
      smb_pkg::FN_CLEAR_SET: begin
        m.msg.protocol_subcode = smb_pkg::SUB_CLEAR_SET;                      // [RULE_12]
        m.msg.return_route_id  = rid;                                         // [RULE_12]
        m.msg.lun              = r.lun;                                       // [RULE_12]
        m.length               = smb_pkg::LEN_ROUTE_LUN;
      end
      smb_pkg::FN_TARGET_RST: begin
        m.msg.protocol_subcode = smb_pkg::SUB_TARGET_RST;                     // [RULE_13]
        m.msg.return_route_id  = rid;                                         // [RULE_13]
        m.length               = smb_pkg::LEN_ROUTE_ONLY;
      end
      default: begin
        m.msg.protocol_subcode = smb_pkg::SUB_LUN_RST;                        // [RULE_14]
        m.msg.return_route_id  = rid;                                         // [RULE_14]
        m.msg.lun              = r.lun;                                       // [RULE_14]
        m.length               = smb_pkg::LEN_ROUTE_LUN;
      end
    endcase
    return m;
  endfunction : build_msg

  // Return code carried by a response message to a service response
  function automatic smb_pkg::smb_sr_t map_rsp_rc(input smb_pkg::smb_rc_t rc);
    case (rc)
      smb_pkg::RC_SUCCESS:       return smb_pkg::SR_FUNC_COMPLETE;
      smb_pkg::RC_INVALID_PARAM: return smb_pkg::SR_FUNC_REJECTED;
      default:                   return smb_pkg::SR_DELIVERY_FAIL;
    endcase
  endfunction : map_rsp_rc

  // ==========================================================================
  // Next state
  always_comb begin
    state_nxt            = state_r;
    state_nxt.ds_valid   = 1'b0;
    state_nxt.dr_valid   = 1'b0;
    state_nxt.tw_valid   = 1'b0;
    state_nxt.cc_valid   = 1'b0;
    state_nxt.route_req  = 1'b0;
    state_nxt.send_valid = 1'b0;
    state_nxt.rsp_valid  = 1'b0;
    state_nxt.exec_valid = 1'b0;

    if (rd_done_valid) begin
      state_nxt.ds_valid = 1'b1;                                              // [RULE_01]
      state_nxt.ds       = '{dest: rd_done.dest, src: own_id, tag: rd_done.tag, lun: rd_done.lun}; // [RULE_01]
    end
    if (wr_done_valid) begin
      state_nxt.dr_valid = 1'b1;                                              // [RULE_05]
      state_nxt.dr       = '{dest: wr_done.dest, src: own_id, tag: wr_done.tag, lun: wr_done.lun}; // [RULE_05]
    end
    if (dout_valid) begin
      state_nxt.tw_valid = 1'b1;                                              // [RULE_02]
      state_nxt.tw       = '{dest: dout_req.dest, tag: dout_req.tag, buf_addr: dout_req.buf_addr,
                             offset: dout_req.offset, count: dout_req.count}; // [RULE_02]
      state_nxt.tw_lun   = dout_req.lun;
    end
    // Context of the last target write names the failing command
    if (tw_ret_valid && tw_ret == smb_pkg::RC_FAILED) begin
      state_nxt.cc_valid = 1'b1;                                              // [RULE_03]
      state_nxt.cc       = '{dest: state_r.tw.dest, tag: state_r.tw.tag, lun: state_r.tw_lun,
                             resp: smb_pkg::SR_DELIVERY_FAIL};                // [RULE_03]
    end

    case (state_r.st)
      smb_pkg::ST_IDLE: begin
        if (tm_valid && state_r.ready) begin
          state_nxt.req = tm_req;
          if (tm_req.fn == smb_pkg::FN_TERMINATE) begin
            state_nxt.rsp_valid = 1'b1;                                       // [RULE_15]
            state_nxt.rsp       = smb_pkg::SR_FUNC_REJECTED;                  // [RULE_15]
          end else if (tm_req.fn == smb_pkg::FN_CLEAR_ACA) begin
            state_nxt.send       = build_msg(tm_req, '0);                     // [RULE_11]
            state_nxt.send_valid = 1'b1;                                      // [RULE_06]
            state_nxt.st         = smb_pkg::ST_SEND;
          end else begin
            state_nxt.route_req = 1'b1;
            state_nxt.st        = smb_pkg::ST_LOOKUP;
          end
        end
      end
      smb_pkg::ST_LOOKUP: begin
        if (route_ack) begin
          state_nxt.send       = build_msg(state_r.req, route_id);
          state_nxt.send_valid = 1'b1;                                        // [RULE_06]
          state_nxt.st         = smb_pkg::ST_SEND;
        end
      end
      smb_pkg::ST_SEND: begin
        if (send_ret_valid) begin
          state_nxt.rsp_valid = 1'b1;
          if (send_ret == smb_pkg::RC_SUCCESS) begin
            state_nxt.rsp = smb_pkg::SR_FUNC_COMPLETE;                        // [RULE_07]
            state_nxt.st  = smb_pkg::ST_WAIT_RSP;                             // [RULE_08]
          end else begin
            state_nxt.rsp = smb_pkg::SR_DELIVERY_FAIL;                        // [RULE_07]
            state_nxt.st  = smb_pkg::ST_IDLE;
          end
        end
      end
      smb_pkg::ST_WAIT_RSP: begin
        if (tm_msg_valid) begin
          state_nxt.exec_valid = 1'b1;                                        // [RULE_16]
          state_nxt.exec_rsp   = map_rsp_rc(tm_msg_rc);                       // [RULE_16]
          state_nxt.st         = smb_pkg::ST_IDLE;                            // [RULE_17]
        end
      end
      default: begin
        state_nxt.st = smb_pkg::ST_IDLE;
      end
    endcase
    // Requester stalls while a function is outstanding, keeping arrival order
    state_nxt.ready = (state_nxt.st == smb_pkg::ST_IDLE) && !state_nxt.rsp_valid; // [RULE_08] [RULE_17]
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign data_sent_valid = state_r.ds_valid;
  assign data_sent       = state_r.ds;
  assign dout_rcvd_valid = state_r.dr_valid;
  assign dout_rcvd       = state_r.dr;
  assign tw_valid        = state_r.tw_valid;
  assign tw              = state_r.tw;
  assign cmd_cpl_valid   = state_r.cc_valid;
  assign cmd_cpl         = state_r.cc;
  assign tm_ready        = state_r.ready;
  assign route_req       = state_r.route_req;
  assign route_dest      = state_r.req.dest;
  assign send_valid      = state_r.send_valid;
  assign send            = state_r.send;
  assign tm_rsp_valid    = state_r.rsp_valid;
  assign tm_rsp          = state_r.rsp;
  assign tm_exec_valid   = state_r.exec_valid;
  assign tm_exec_rsp     = state_r.exec_rsp;

endmodule : smb_msg_builder

// file: verification/smb_msg_builder_sva.sv
`timescale 1ns/1ps
// ====================
// Port-level protocol checks
module smb_msg_builder_sva (
  input wire logic                        core_clk,
  input wire logic                        rst,
  input wire logic [smb_pkg::ID_W-1:0]    own_id,
  input wire logic                        rd_done_valid,
  input wire smb_pkg::smb_xfer_done_t     rd_done,
  input wire logic                        data_sent_valid,
  input wire smb_pkg::smb_confirm_t       data_sent,
  input wire logic                        dout_valid,
  input wire smb_pkg::smb_dout_req_t      dout_req,
  input wire logic                        tw_valid,
  input wire smb_pkg::smb_twrite_t        tw,
  input wire logic                        tw_ret_valid,
  input wire smb_pkg::smb_rc_t            tw_ret,
  input wire logic                        cmd_cpl_valid,
  input wire smb_pkg::smb_cmd_cpl_t       cmd_cpl,
  input wire logic                        tm_valid,
  input wire logic                        tm_ready,
  input wire smb_pkg::smb_tm_req_t        tm_req,
  input wire logic                        route_req,
  input wire logic                        route_ack,
  input wire logic [smb_pkg::ROUTE_W-1:0] route_id,
  input wire logic                        send_valid,
  input wire smb_pkg::smb_send_t          send,
  input wire logic                        send_ret_valid,
  input wire smb_pkg::smb_rc_t            send_ret,
  input wire logic                        tm_rsp_valid,
  input wire smb_pkg::smb_sr_t            tm_rsp,
  input wire logic                        tm_msg_valid,
  input wire smb_pkg::smb_rc_t            tm_msg_rc,
  input wire logic                        tm_exec_valid,
  input wire smb_pkg::smb_sr_t            tm_exec_rsp
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_take;
    tm_valid && tm_ready;
  endsequence
  sequence s_looked;
    s_take ##1 route_req ##[1:8] route_ack;
  endsequence
  a_rd_confirm: assert property (rd_done_valid |=> data_sent_valid &&
    data_sent == {$past(rd_done.dest), $past(own_id), $past(rd_done.tag), $past(rd_done.lun)})
    else $error("data sent confirmation wrong");
  a_tw_map: assert property (dout_valid |=> tw_valid && tw == {$past(dout_req.dest),
    $past(dout_req.tag), $past(dout_req.buf_addr), $past(dout_req.offset), $past(dout_req.count)})
    else $error("target write mapping wrong");
  a_tw_fail: assert property (tw_ret_valid && tw_ret == smb_pkg::RC_FAILED |=>
    cmd_cpl_valid && cmd_cpl.resp == smb_pkg::SR_DELIVERY_FAIL) else $error("no failure completion");
  a_send_fixed: assert property (send_valid |-> send.control == smb_pkg::CTRL_SEND &&
    send.msg.message_code == 8'h83 && send.msg.tag == 8'h00) else $error("fixed message fields wrong");
  a_send_rsp: assert property (send_ret_valid |=> tm_rsp_valid && tm_rsp ==
    ($past(send_ret) == smb_pkg::RC_SUCCESS ? smb_pkg::SR_FUNC_COMPLETE : smb_pkg::SR_DELIVERY_FAIL))
    else $error("send response mapping wrong");
  a_take_busy: assert property (s_take |=> !tm_ready) else $error("second request accepted");
  a_route_used: assert property (s_looked |=> send_valid &&
    send.msg.return_route_id == $past(route_id)) else $error("looked-up route not sent");
  a_terminate: assert property (s_take ##0 tm_req.fn == smb_pkg::FN_TERMINATE |=> tm_rsp_valid &&
    tm_rsp == smb_pkg::SR_FUNC_REJECTED && !send_valid && !route_req) else $error("terminate not rejected");
  a_exec_map: assert property (tm_msg_valid |=> tm_exec_valid && tm_exec_rsp ==
    ($past(tm_msg_rc) == smb_pkg::RC_SUCCESS ? smb_pkg::SR_FUNC_COMPLETE :
     $past(tm_msg_rc) == smb_pkg::RC_INVALID_PARAM ? smb_pkg::SR_FUNC_REJECTED : smb_pkg::SR_DELIVERY_FAIL))
    else $error("response message mapping wrong");
  a_release_next: assert property (tm_rsp_valid && tm_rsp != smb_pkg::SR_FUNC_COMPLETE |=>
    tm_ready) else $error("request path not released");
  a_exec_release: assert property (tm_exec_valid |-> tm_ready) else $error("path busy after response");
endmodule : smb_msg_builder_sva

bind smb_msg_builder smb_msg_builder_sva u_sva (.*);

// file: verification/smb_far_end.sv
`timescale 1ns/1ps
// ====================
// Transport and remote target stand-in
module smb_far_end (
  input wire logic                        core_clk,
  input wire logic                        rst,
  input wire logic                        route_req,
  input wire logic                        send_valid,
  input wire logic [smb_pkg::ROUTE_W-1:0] rt_val,
  input wire logic [1:0]                  dly,
  input wire smb_pkg::smb_rc_t            snd_rc,
  input wire smb_pkg::smb_rc_t            msg_rc,
  output logic                            route_ack,
  output logic [smb_pkg::ROUTE_W-1:0]     route_id,
  output logic                            send_ret_valid,
  output smb_pkg::smb_rc_t                send_ret,
  output logic                            tm_msg_valid,
  output smb_pkg::smb_rc_t                tm_msg_rc
);
  initial begin
    {route_ack, send_ret_valid, tm_msg_valid, route_id} = '0;
    send_ret = smb_pkg::RC_FAILED;
    tm_msg_rc = smb_pkg::RC_FAILED;
  end
  // Lookup answer after a chosen delay; released id is inverted
  always @(posedge core_clk) begin
    if (!rst && route_req === 1'h1) begin
      repeat (dly) @(posedge core_clk);
      #1 {route_ack, route_id} = {1'h1, rt_val};
      @(posedge core_clk);
      #1 {route_ack, route_id} = {1'h0, ~rt_val};
    end
  end
  // Send return, then the remote response message after a success
  always @(posedge core_clk) begin
    if (!rst && send_valid === 1'h1) begin
      repeat (dly) @(posedge core_clk);
      #1 send_ret_valid = 1'h1;
      send_ret = snd_rc;
      @(posedge core_clk);
      #1 send_ret_valid = 1'h0;
      send_ret = smb_pkg::smb_rc_t'(~snd_rc);
      if (snd_rc == smb_pkg::RC_SUCCESS) begin
        repeat (2 + dly) @(posedge core_clk);
        #1 tm_msg_valid = 1'h1;
        tm_msg_rc = msg_rc;
        @(posedge core_clk);
        #1 tm_msg_valid = 1'h0;
        tm_msg_rc = smb_pkg::smb_rc_t'(~msg_rc);
      end
    end
  end
endmodule : smb_far_end

// file: verification/smb_msg_builder_bench.sv
`timescale 1ns/1ps
// ====================
// Self-checking bench
module smb_msg_builder_bench;
  logic                        core_clk = 1'h0;
  logic                        rst = 1'h1;
  logic [smb_pkg::ID_W-1:0]    own_id, route_dest;
  logic                        rd_done_valid, wr_done_valid, dout_valid, tw_ret_valid, tm_valid, route_ack;
  logic                        route_req, send_ret_valid, tm_msg_valid, data_sent_valid, dout_rcvd_valid;
  logic                        tw_valid, cmd_cpl_valid, tm_ready, send_valid, tm_rsp_valid, tm_exec_valid;
  logic [smb_pkg::ROUTE_W-1:0] route_id, rt_val;
  logic [1:0]                  dly;
  smb_pkg::smb_xfer_done_t     rd_done, wr_done;
  smb_pkg::smb_dout_req_t      dout_req, lst;
  smb_pkg::smb_rc_t            tw_ret, send_ret, tm_msg_rc, snd_rc, msg_rc;
  smb_pkg::smb_tm_req_t        tm_req;
  smb_pkg::smb_confirm_t       data_sent, dout_rcvd;
  smb_pkg::smb_twrite_t        tw;
  smb_pkg::smb_cmd_cpl_t       cmd_cpl;
  smb_pkg::smb_send_t          send, last_send;
  smb_pkg::smb_sr_t            tm_rsp, tm_exec_rsp;
  int                          fail_count = 0, n_checks = 0, n_send = 0, cyc = 0;
  localparam logic [7:0] SUBS [6] = '{8'h30, 8'h31, 8'h34, 8'h32, 8'h33, 8'h35};
  localparam logic [7:0] LENS [6] = '{smb_pkg::LEN_ROUTE_SECOND_TASK_TAG, smb_pkg::LEN_ROUTE_LUN, smb_pkg::LEN_LUN_ONLY,
                                      smb_pkg::LEN_ROUTE_LUN, smb_pkg::LEN_ROUTE_ONLY, smb_pkg::LEN_ROUTE_LUN};
  smb_msg_builder dut (.*);
  smb_far_end u_far (.*);
  always #5 core_clk = ~core_clk;

  function automatic smb_pkg::smb_send_t exp_send(smb_pkg::smb_tm_req_t q, logic [31:0] rt);
    smb_pkg::smb_send_t s;
    s = '0;
    s.dest = q.dest;
    s.length = LENS[q.fn];
    s.msg.message_code = 8'h83;
    s.msg.protocol_subcode = SUBS[q.fn];
    s.msg.return_route_id = (q.fn == smb_pkg::FN_CLEAR_ACA) ? 32'h0 : rt;
    s.msg.lun = (q.fn inside {smb_pkg::FN_ABORT_TASK, smb_pkg::FN_TARGET_RST}) ? 64'h0 : q.lun;
    s.msg.second_task_tag = (q.fn == smb_pkg::FN_ABORT_TASK) ? q.tag : 16'h0;
    return s;
  endfunction : exp_send

  function automatic smb_pkg::smb_sr_t exp_exec(smb_pkg::smb_rc_t rc);
    return rc == smb_pkg::RC_SUCCESS ? smb_pkg::SR_FUNC_COMPLETE :
           rc == smb_pkg::RC_INVALID_PARAM ? smb_pkg::SR_FUNC_REJECTED : smb_pkg::SR_DELIVERY_FAIL;
  endfunction : exp_exec

  task automatic chk(input logic [255:0] a, input logic [255:0] e);
    n_checks++;
    if (a !== e) begin
      fail_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, a, e);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  // Request is raised and held until the path is free, then taken on the next edge
  task automatic do_tm(input int k);
    smb_pkg::smb_tm_req_t q;
    int n;
    int s0;
    q = (k == 0) ? '1 : {3'h0, 16'($urandom), $urandom, $urandom, 16'($urandom)};
    q.fn = smb_pkg::smb_tm_fn_t'(k % 7);
    snd_rc = smb_pkg::smb_rc_t'(k / 7);
    msg_rc = smb_pkg::smb_rc_t'($urandom_range(3));
    {rt_val, dly} = {$urandom, 2'($urandom)};
    {tm_req, tm_valid} = {q, 1'h1};
    for (n = 0; n < 30 && tm_ready !== 1'h1; n++) @(posedge core_clk) #1;
    @(posedge core_clk);
    #1 tm_valid = 1'h0;
    s0 = n_send;
    chk(tm_ready, 1'h0);
    chk(route_dest, q.dest);
    for (n = 0; n < 30 && tm_rsp_valid !== 1'h1; n++) @(posedge core_clk) #1;
    if (q.fn == smb_pkg::FN_TERMINATE) begin
      chk({n, tm_rsp_valid, tm_rsp, n_send}, {32'h0, 1'h1, smb_pkg::SR_FUNC_REJECTED, s0});
    end else begin
      chk({last_send, n_send}, {exp_send(q, rt_val), s0 + 1});
      chk({tm_rsp_valid, tm_rsp}, {1'h1, snd_rc == smb_pkg::RC_SUCCESS ? smb_pkg::SR_FUNC_COMPLETE :
          smb_pkg::SR_DELIVERY_FAIL});
      if (snd_rc == smb_pkg::RC_SUCCESS) begin
        for (n = 0; n < 30 && tm_exec_valid !== 1'h1; n++) @(posedge core_clk) #1;
        chk({tm_exec_valid, tm_exec_rsp}, {1'h1, exp_exec(msg_rc)});
      end
    end
  endtask : do_tm

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (send_valid === 1'h1) begin
      last_send <= send;
      n_send <= n_send + 1;
    end
    if (cyc == 5000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    void'($urandom(74));
    {rd_done_valid, wr_done_valid, dout_valid, tw_ret_valid, tm_valid, rd_done, wr_done, dout_req, tm_req} = '0;
    {dly, rt_val} = '0;
    tw_ret = smb_pkg::RC_SUCCESS;
    snd_rc = smb_pkg::RC_SUCCESS;
    msg_rc = smb_pkg::RC_SUCCESS;
    own_id = 16'($urandom);
    repeat (3) @(posedge core_clk);
    #1 rst = 1'h0;
    // Random read and write events each cycle; data-out and target-write returns on alternate cycles
    for (int i = 0; i < 40; i++) begin
      {rd_done, wr_done} = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      dout_req = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, 16'($urandom)};
      {rd_done_valid, wr_done_valid, dout_valid, tw_ret_valid} = {2'($urandom), ~i[0], i[0]};
      tw_ret = smb_pkg::smb_rc_t'($urandom_range(3));
      @(posedge core_clk);
      #1 chk({data_sent_valid, dout_rcvd_valid, tw_valid}, {rd_done_valid, wr_done_valid, dout_valid});
      if (rd_done_valid) chk(data_sent, {rd_done.dest, own_id, rd_done.tag, rd_done.lun});
      if (wr_done_valid) chk(dout_rcvd, {wr_done.dest, own_id, wr_done.tag, wr_done.lun});
      if (dout_valid) chk(tw, {dout_req.dest, dout_req.tag, dout_req.buf_addr, dout_req.offset, dout_req.count});
      chk(cmd_cpl_valid, tw_ret_valid && tw_ret == smb_pkg::RC_FAILED);
      if (cmd_cpl_valid === 1'h1) chk(cmd_cpl, {lst.dest, lst.tag, lst.lun, smb_pkg::SR_DELIVERY_FAIL});
      if (dout_valid) lst = dout_req;
    end
    {rd_done_valid, wr_done_valid, dout_valid, tw_ret_valid} = 4'h0;
    for (int k = 0; k < 28; k++) do_tm(k);
    repeat (5) @(posedge core_clk);
    end_sim();
  end
endmodule : smb_msg_builder_bench
